// ---- logic/wake_flag_bit.sv ----
// One sticky status flag: hardware set, write-one clear, automatic clear
`timescale 1ns/100ps
`default_nettype none
module wake_flag_bit (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Control
	input wire logic set_evt,
	input wire logic clr_evt,
	// State
	output logic flag
);
	logic flag_q;
	logic flag_d;

	// Set wins so an event in the clearing cycle is kept
	always_comb begin
		flag_d = set_evt | (flag_q & ~clr_evt);
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

	assign flag = flag_q;
endmodule : wake_flag_bit
`default_nettype wire

// ---- logic/wake_on_lan_ctrl_status.sv ----
// Wake-on-LAN control and status bank with receive store gating
//
// Behaviour
// - Store-wake option set: store the waking frame, then later good filtered frames.
// - Store-wake option clear: drop waking frame, store later good filtered frames only.
// - Wake not caused by a frame: store all frames received afterwards; the code stores only the good filtered ones.
// - Store-wake option matters only in deepest suspend mode.
// - Bit 7 sets on valid frame matching station address; software clearable.
// - Bit 6 sets on valid pattern wake frame; software clearable.
// - Bit 5 sets on valid magic frame; software clearable.
// - Bit 4 sets on valid broadcast frame; software clearable.
// - Resume completion clears bits 7 to 4 when resume-clears-flags is set.
// - Bit 3 enables waking on station address match.
// - Bit 2 enables waking on programmed pattern frames.
// - Bit 1 enables magic frame wake mode.
// - Bit 0 enables waking on broadcast frames.
// - Resume completion clears bits 3 to 0 when resume-clears-enables is set.
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "wake_defines.svh"
module wake_on_lan_ctrl_status (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [`WK_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Suspend and resume
	input wire logic suspend_active,
	input wire wake_pkg::suspend_mode_e suspend_mode,
	input wire logic resume_done,
	input wire logic other_wake,
	// Receive frame indications
	input wire logic frame_done,
	input wire logic frame_good,
	input wire logic frame_pass,
	input wire logic frame_da_match,
	input wire logic frame_pattern_match,
	input wire logic frame_magic,
	input wire logic frame_broadcast,
	// Enables towards the filter engine
	output logic addr_match_wake_on,
	output logic pattern_wake_on,
	output logic magic_wake_on,
	output logic broadcast_wake_on,
	// Receive FIFO control and wake
	output logic frame_store,
	output logic frame_discard,
	output logic wake_request,
	output logic irq
);
	import wake_pkg::*;

	// Register state
	logic [3:0] wake_on_q;
	logic [3:0] wake_on_d;
	logic store_wake_q;
	logic store_wake_d;
	logic resume_clears_flags_q;
	logic resume_clears_flags_d;
	logic resume_clears_enables_q;
	logic resume_clears_enables_d;
	logic [`WK_IRQ_W-1:0] irq_mask_q;
	logic [`WK_IRQ_W-1:0] irq_mask_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;

	// Receive gating state
	rx_state_e rx_state_q;
	rx_state_e rx_state_d;
	logic store_q;
	logic store_d;
	logic discard_q;
	logic discard_d;
	logic wake_q;
	logic wake_d;

	// Decodes and events
	logic wr_wcs;
	logic wr_ctrl;
	logic wr_irq_sts;
	logic wr_irq_mask;
	logic valid_frame;
	logic wake_hit;
	logic deepest;
	logic [3:0] seen_set;
	logic [3:0] seen_clr;
	logic [3:0] seen;
	logic [`WK_IRQ_W-1:0] irq_set;
	logic [`WK_IRQ_W-1:0] irq_clr;
	logic [`WK_IRQ_W-1:0] irq_sts;

	assign wr_wcs = reg_wr && (reg_addr == `WK_OFF_WCS);
	assign wr_ctrl = reg_wr && (reg_addr == `WK_OFF_CTRL);
	assign wr_irq_sts = reg_wr && (reg_addr == `WK_OFF_IRQ_STS);
	assign wr_irq_mask = reg_wr && (reg_addr == `WK_OFF_IRQ_MASK);

	// Valid means uncorrupted; filters do not gate the status flags
	assign valid_frame = frame_done & frame_good;
	assign deepest = (suspend_mode == SUSP_MODE_DEEPEST);

	// Only an armed device turns a matching frame into a wake event
	always_comb begin
		wake_hit = 1'b0;
		if (rx_state_q == RX_ARMED && valid_frame) begin
			wake_hit = (frame_da_match & wake_on_q[`WK_BIT_ADDR_ON])
				| (frame_pattern_match & wake_on_q[`WK_BIT_PATTERN_ON])
				| (frame_magic & wake_on_q[`WK_BIT_MAGIC_ON])
				| (frame_broadcast & wake_on_q[`WK_BIT_BCAST_ON]);
		end
	end

	// Frame-seen flags, bit order 4..7 as broadcast, magic, pattern, address
	always_comb begin
		seen_set[0] = valid_frame & frame_broadcast;
		seen_set[1] = valid_frame & frame_magic;
		seen_set[2] = valid_frame & frame_pattern_match;
		seen_set[3] = valid_frame & frame_da_match;
		seen_clr = 4'h0;
		if (wr_wcs) begin
			seen_clr = reg_wdata[`WK_BIT_ADDR_SEEN:`WK_BIT_BCAST_SEEN];
		end
		if (resume_done && resume_clears_flags_q) begin
			seen_clr = 4'hf;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_seen
			wake_flag_bit u_seen (
				.ref_clk(ref_clk),
				.sys_rst(sys_rst),
				.set_evt(seen_set[gi]),
				.clr_evt(seen_clr[gi]),
				.flag(seen[gi])
			);
		end
	endgenerate

	// Interrupt events: wake raised and resume completed
	always_comb begin
		irq_set = '0;
		irq_set[`WK_BIT_IRQ_WAKE] = wake_d;
		irq_set[`WK_BIT_IRQ_RESUME] = resume_done;
		irq_clr = '0;
		if (wr_irq_sts) begin
			irq_clr = reg_wdata[`WK_IRQ_W-1:0];
		end
	end

	generate
		for (gi = 0; gi < `WK_IRQ_W; gi = gi + 1) begin : g_irq
			wake_flag_bit u_irq (
				.ref_clk(ref_clk),
				.sys_rst(sys_rst),
				.set_evt(irq_set[gi]),
				.clr_evt(irq_clr[gi]),
				.flag(irq_sts[gi])
			);
		end
	endgenerate

	// Software-written configuration
	always_comb begin
		wake_on_d = wake_on_q;
		store_wake_d = store_wake_q;
		resume_clears_flags_d = resume_clears_flags_q;
		resume_clears_enables_d = resume_clears_enables_q;
		irq_mask_d = irq_mask_q;
		if (wr_wcs) begin
			wake_on_d = reg_wdata[`WK_BIT_ADDR_ON:`WK_BIT_BCAST_ON];
			store_wake_d = reg_wdata[`WK_BIT_STORE_WAKE];
		end
		// A resume clear overrides a write in the same cycle
		if (resume_done && resume_clears_enables_q) begin
			wake_on_d = 4'h0;
		end
		if (wr_ctrl) begin
			resume_clears_flags_d = reg_wdata[`WK_BIT_RES_CLR_FLAGS];
			resume_clears_enables_d = reg_wdata[`WK_BIT_RES_CLR_ENABLES];
		end
		if (wr_irq_mask) begin
			irq_mask_d = reg_wdata[`WK_IRQ_W-1:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wake_on_q <= `WK_RST_ENABLES;
			store_wake_q <= `WK_RST_STORE;
			{resume_clears_enables_q, resume_clears_flags_q} <= `WK_RST_CTRL;
			irq_mask_q <= `WK_RST_MASK;
		end else begin
			wake_on_q <= wake_on_d;
			store_wake_q <= store_wake_d;
			resume_clears_flags_q <= resume_clears_flags_d;
			resume_clears_enables_q <= resume_clears_enables_d;
			irq_mask_q <= irq_mask_d;
		end
	end

	// Receive gating: what happens to each finished frame
	always_comb begin
		rx_state_d = rx_state_q;
		store_d = 1'b0;
		discard_d = 1'b0;
		wake_d = 1'b0;
		case (rx_state_q)
			RX_NORMAL: begin
				if (suspend_active) begin
					rx_state_d = RX_ARMED;
				end
				if (frame_done) begin
					store_d = frame_good & frame_pass;
					discard_d = ~(frame_good & frame_pass);
				end
			end
			RX_ARMED: begin
				if (wake_hit) begin
					wake_d = 1'b1;
					rx_state_d = RX_WOKE;
					// Outside the deepest mode the option is ignored
					store_d = deepest & store_wake_q & frame_pass;
					discard_d = ~(deepest & store_wake_q & frame_pass);
				end else if (other_wake) begin
					wake_d = 1'b1;
					rx_state_d = RX_WOKE;
					if (frame_done) begin
						discard_d = 1'b1;
					end
				end else if (frame_done) begin
					discard_d = 1'b1;
				end
				// Resume without a wake leaves suspend quietly
				if (!suspend_active && !wake_hit && !other_wake) begin
					rx_state_d = RX_NORMAL;
				end
			end
			RX_WOKE: begin
				if (frame_done) begin
					store_d = frame_good & frame_pass;
					discard_d = ~(frame_good & frame_pass);
				end
				if (resume_done || !suspend_active) begin
					rx_state_d = RX_NORMAL;
				end
			end
			default: begin
				rx_state_d = RX_NORMAL;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rx_state_q <= RX_NORMAL;
			store_q <= 1'b0;
			discard_q <= 1'b0;
			wake_q <= 1'b0;
		end else begin
			rx_state_q <= rx_state_d;
			store_q <= store_d;
			discard_q <= discard_d;
			wake_q <= wake_d;
		end
	end

	// Read path; unmapped addresses and idle cycles read zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				`WK_OFF_WCS: begin
					rdata_d[`WK_BIT_STORE_WAKE] = store_wake_q;
					rdata_d[`WK_BIT_ADDR_SEEN:`WK_BIT_BCAST_SEEN] = seen;
					rdata_d[`WK_BIT_ADDR_ON:`WK_BIT_BCAST_ON] = wake_on_q;
				end
				`WK_OFF_CTRL: begin
					rdata_d[`WK_BIT_RES_CLR_FLAGS] = resume_clears_flags_q;
					rdata_d[`WK_BIT_RES_CLR_ENABLES] = resume_clears_enables_q;
				end
				`WK_OFF_IRQ_STS: begin
					rdata_d[`WK_IRQ_W-1:0] = irq_sts;
				end
				`WK_OFF_IRQ_MASK: begin
					rdata_d[`WK_IRQ_W-1:0] = irq_mask_q;
				end
				default: begin
					rdata_d = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign addr_match_wake_on = wake_on_q[`WK_BIT_ADDR_ON];
	assign pattern_wake_on = wake_on_q[`WK_BIT_PATTERN_ON];
	assign magic_wake_on = wake_on_q[`WK_BIT_MAGIC_ON];
	assign broadcast_wake_on = wake_on_q[`WK_BIT_BCAST_ON];
	assign frame_store = store_q;
	assign frame_discard = discard_q;
	assign wake_request = wake_q;
	// Level interrupt, no extra register so it drops with the clearing write
	assign irq = |(irq_sts & irq_mask_q);
endmodule : wake_on_lan_ctrl_status
`default_nettype wire

// ---- pkg/wake_defines.svh ----
// Offsets, field positions and reset values of the wake-on-LAN register bank
`ifndef WAKE_DEFINES_SVH
`define WAKE_DEFINES_SVH

`define WK_ADDR_W 9
`define WK_OFF_WCS 9'h140
`define WK_OFF_CTRL 9'h180
`define WK_OFF_IRQ_STS 9'h184
`define WK_OFF_IRQ_MASK 9'h188

`define WK_BIT_BCAST_ON 0
`define WK_BIT_MAGIC_ON 1
`define WK_BIT_PATTERN_ON 2
`define WK_BIT_ADDR_ON 3
`define WK_BIT_BCAST_SEEN 4
`define WK_BIT_MAGIC_SEEN 5
`define WK_BIT_PATTERN_SEEN 6
`define WK_BIT_ADDR_SEEN 7
`define WK_BIT_STORE_WAKE 8

`define WK_BIT_RES_CLR_FLAGS 0
`define WK_BIT_RES_CLR_ENABLES 1

`define WK_BIT_IRQ_WAKE 0
`define WK_BIT_IRQ_RESUME 1
`define WK_IRQ_W 2

`define WK_RST_ENABLES 4'h0
`define WK_RST_STORE 1'b0
`define WK_RST_CTRL 2'h0
`define WK_RST_MASK 2'h0

`endif

// ---- pkg/wake_pkg.sv ----
// Types shared by the wake-on-LAN register bank
package wake_pkg;

	typedef enum logic [1:0] {
		SUSP_MODE_0 = 2'b00,
		SUSP_MODE_1 = 2'b01,
		SUSP_MODE_2 = 2'b10,
		SUSP_MODE_DEEPEST = 2'b11
	} suspend_mode_e;

	typedef enum logic [1:0] {
		RX_NORMAL = 2'b00,
		RX_ARMED = 2'b01,
		RX_WOKE = 2'b10
	} rx_state_e;

endpackage : wake_pkg

// ---- sim/testbench.sv ----
// Self-checking bench for the wake-on-LAN register bank
`timescale 1ns/100ps
`default_nettype none
`include "wake_defines.svh"
module testbench;
	import wake_pkg::*;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [8:0] reg_addr = 9'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic suspend_active = 1'b0;
	logic resume_done = 1'b0;
	logic other_wake = 1'b0;
	suspend_mode_e suspend_mode = SUSP_MODE_0;
	logic frame_done = 1'b0;
	logic frame_good = 1'b0;
	logic frame_pass = 1'b0;
	logic [3:0] ty = 4'h0;
	logic [3:0] en;
	logic frame_store, frame_discard, wake_request, irq;
	int n_errors = 0;
	int samples_checked = 0;
	always #50 ref_clk = ~ref_clk;
	wake_on_lan_ctrl_status dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.suspend_active(suspend_active), .suspend_mode(suspend_mode), .resume_done(resume_done),
		.other_wake(other_wake), .frame_done(frame_done), .frame_good(frame_good),
		.frame_pass(frame_pass), .frame_da_match(ty[3]), .frame_pattern_match(ty[2]),
		.frame_magic(ty[1]), .frame_broadcast(ty[0]), .addr_match_wake_on(en[3]),
		.pattern_wake_on(en[2]), .magic_wake_on(en[1]), .broadcast_wake_on(en[0]),
		.frame_store(frame_store), .frame_discard(frame_discard), .wake_request(wake_request),
		.irq(irq));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [8:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk("reg_rdata", exp, reg_rdata);
	endtask : rd
	task automatic frame(input logic [3:0] t, input logic ok, input logic p, input logic st,
		input logic wk);
		@(posedge ref_clk);
		frame_done <= 1'b1;
		ty <= t;
		frame_good <= ok;
		frame_pass <= p;
		@(posedge ref_clk);
		frame_done <= 1'b0;
		#1;
		chk("frame_store", st, frame_store);
		chk("frame_discard", !st, frame_discard);
		chk("wake_request", wk, wake_request);
	endtask : frame
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	initial begin
		#(3000 * 100);
		n_errors++;
		print_verdict();
	end
	initial begin
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd(`WK_OFF_WCS, 32'h0);
		rd(`WK_OFF_CTRL, 32'h0);
		rd(`WK_OFF_IRQ_MASK, 32'h0);
		wr(9'h004, 32'hffffffff);
		rd(9'h004, 32'h0);
		@(posedge ref_clk);
		suspend_active <= 1'b1;
		wr(`WK_OFF_WCS, 32'hffffffff);
		rd(`WK_OFF_WCS, 32'h10f);
		chk("enables", 4'hf, en);
		wr(`WK_OFF_WCS, 32'h0);
		@(posedge ref_clk);
		suspend_active <= 1'b0;
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			frame(4'h1 << i, 1'b0, 1'b1, 1'b0, 1'b0);
			frame(4'h1 << i, 1'b1, i[0], i[0], 1'b0);
			wr(`WK_OFF_WCS, 32'h0);
			rd(`WK_OFF_WCS, 32'h10 << i);
			wr(`WK_OFF_WCS, 32'h10 << i);
		end
		rd(`WK_OFF_WCS, 32'h0);
		$display("test flags done");
		wr(`WK_OFF_IRQ_MASK, 32'h1);
		for (int s = 0; s < 2; s++) begin
			for (int m = 0; m < 4; m++) begin
				@(posedge ref_clk);
				suspend_mode <= suspend_mode_e'(m[1:0]);
				suspend_active <= 1'b1;
				wr(`WK_OFF_WCS, {23'h0, s[0], 8'h02});
				frame(4'h1, 1'b1, 1'b1, 1'b0, 1'b0);
				frame(4'h2, 1'b1, 1'b1, s == 1 && m == 3, 1'b1);
				frame(4'h1, 1'b1, 1'b1, 1'b1, 1'b0);
				wr(`WK_OFF_WCS, 32'h0);
				@(posedge ref_clk);
				suspend_active <= 1'b0;
			end
		end
		#1 chk("irq", 1'b1, irq);
		wr(`WK_OFF_IRQ_MASK, 32'h0);
		chk("irq", 1'b0, irq);
		wr(`WK_OFF_IRQ_STS, 32'h3);
		wr(`WK_OFF_IRQ_MASK, 32'h3);
		rd(`WK_OFF_IRQ_MASK, 32'h3);
		chk("irq", 1'b0, irq);
		$display("test wake done");
		@(posedge ref_clk);
		suspend_active <= 1'b1;
		wr(`WK_OFF_WCS, 32'h001);
		@(posedge ref_clk);
		other_wake <= 1'b1;
		@(posedge ref_clk);
		other_wake <= 1'b0;
		#1 chk("wake_request", 1'b1, wake_request);
		frame(4'h8, 1'b1, 1'b1, 1'b1, 1'b0);
		wr(`WK_OFF_WCS, 32'h0);
		@(posedge ref_clk);
		suspend_active <= 1'b0;
		$display("test other wake done");
		for (int c = 1; c < 3; c++) begin
			wr(`WK_OFF_CTRL, c);
			rd(`WK_OFF_CTRL, c);
			@(posedge ref_clk);
			suspend_active <= 1'b1;
			wr(`WK_OFF_WCS, 32'h00f);
			frame(4'hf, 1'b1, 1'b1, 1'b0, 1'b1);
			@(posedge ref_clk);
			resume_done <= 1'b1;
			@(posedge ref_clk);
			resume_done <= 1'b0;
			#1 chk("irq", 1'b1, irq);
			rd(`WK_OFF_WCS, c == 1 ? 32'h00f : 32'h0f0);
			rd(`WK_OFF_IRQ_STS, 32'h3);
			wr(`WK_OFF_IRQ_STS, 32'h3);
			chk("irq", 1'b0, irq);
			wr(`WK_OFF_WCS, 32'h0f0);
			@(posedge ref_clk);
			suspend_active <= 1'b0;
		end
		$display("test resume done");
		print_verdict();
	end
endmodule : testbench
`default_nettype wire

// ---- sim/wake_chk_properties.sv ----
// Port checker for the wake-on-LAN register bank
`timescale 1ns/100ps
`default_nettype none
`include "wake_defines.svh"
module wake_chk
	import wake_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [`WK_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// Suspend and frames
	input wire logic suspend_active,
	input wire wake_pkg::suspend_mode_e suspend_mode,
	input wire logic resume_done,
	input wire logic other_wake,
	input wire logic frame_done,
	input wire logic frame_good,
	input wire logic frame_pass,
	input wire logic frame_da_match,
	input wire logic frame_pattern_match,
	input wire logic frame_magic,
	input wire logic frame_broadcast,
	// Outputs
	input wire logic addr_match_wake_on,
	input wire logic pattern_wake_on,
	input wire logic magic_wake_on,
	input wire logic broadcast_wake_on,
	input wire logic frame_store,
	input wire logic frame_discard,
	input wire logic wake_request
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	logic [3:0] en;
	logic [3:0] kind;
	assign en = {addr_match_wake_on, pattern_wake_on, magic_wake_on, broadcast_wake_on};
	assign kind = {frame_da_match, frame_pattern_match, frame_magic, frame_broadcast};
	sequence s_wcs_wr;
		reg_wr && reg_addr == `WK_OFF_WCS && !resume_done;
	endsequence
	sequence s_shallow_wake;
		frame_done && !other_wake && suspend_mode != SUSP_MODE_DEEPEST ##1 wake_request;
	endsequence
	property p_rd;
		reg_rd && reg_addr == `WK_OFF_WCS
			|=> reg_rdata[31:9] == 23'h0 && reg_rdata[3:0] == $past(en);
	endproperty
	a_rd: assert property (p_rd) else $error("bad read of main register");
	property p_idle;
		!reg_rd |=> reg_rdata == 32'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("read data outside read");
	property p_wr;
		s_wcs_wr |=> en == $past(reg_wdata[3:0]);
	endproperty
	a_wr: assert property (p_wr) else $error("enables not written");
	property p_hold;
		!(reg_wr && reg_addr == `WK_OFF_WCS) && !resume_done |=> $stable(en);
	endproperty
	a_hold: assert property (p_hold) else $error("enables changed alone");
	property p_one;
		frame_done |=> frame_store ^ frame_discard;
	endproperty
	a_one: assert property (p_one) else $error("frame not answered once");
	property p_none;
		!frame_done |=> !frame_store && !frame_discard;
	endproperty
	a_none: assert property (p_none) else $error("store without frame");
	property p_norm;
		!suspend_active && !$past(suspend_active) && frame_done
			|=> frame_store == ($past(frame_good) && $past(frame_pass));
	endproperty
	a_norm: assert property (p_norm) else $error("normal store wrong");
	property p_noen;
		frame_done && !other_wake && (kind & en) == 4'h0 |=> !wake_request;
	endproperty
	a_noen: assert property (p_noen) else $error("wake without enable");
	property p_cause;
		wake_request |-> $past(frame_done) || $past(other_wake);
	endproperty
	a_cause: assert property (p_cause) else $error("wake without cause");
	property p_shallow;
		s_shallow_wake |-> frame_discard;
	endproperty
	a_shallow: assert property (p_shallow) else $error("shallow wake frame stored");
	property p_other;
		other_wake && !frame_done |=> !frame_store;
	endproperty
	a_other: assert property (p_other) else $error("store on other wake");
endmodule : wake_chk
bind wake_on_lan_ctrl_status wake_chk chk (.*);
`default_nettype wire
